// file: logic/host_cpu_bus_interface.sv
// Parallel host port of the network controller: decodes host bus cycles
// into register read and write requests, and drives read data and interrupt.
// Assumes all pins synchronous to clock; register file sits on the user side.
`timescale 1ns/1ps

module host_cpu_bus_interface
  import host_bus_pkg::*;
(
  // Clock and reset
  input wire logic clock,
  input wire logic resetn,
  // Host address and control pins
  input wire logic addr_lsb_or_mux_select,
  input wire logic addr_middle_bit,
  input wire logic addr_msb_or_latch_strobe,
  input wire logic chip_select_n,
  input wire logic write_strobe_or_direction,
  input wire logic read_strobe_or_data_strobe,
  input wire logic hw_reset_n,
  input wire logic bus_timing_select,
  // Host data pins, shared_addr_data_low is bits 2:0, data_upper_lines bits 7:3
  input wire logic [7:0] data_in,
  output logic [7:0] data_out,
  output logic data_oe_n,
  // Host interrupt pin
  output logic irq_out_n,
  // Register side
  output logic [2:0] reg_addr,
  output logic [7:0] reg_wdata,
  output logic reg_wr,
  output logic reg_rd,
  input wire logic [7:0] reg_rdata,
  input wire logic irq_pending,
  // Status
  output logic dev_reset_n,
  output logic style_direction,
  output logic mux_mode,
  output logic fast_timing
);

  // ****************************************************************
  // Strap capture and strobe qualification
  // ****************************************************************

  strobe_if rd_strb ();
  strobe_if wr_strb ();

  strap_capture u_strap (
    .clock (clock),
    .resetn (resetn),
    .hw_reset_n (hw_reset_n),
    .mux_select_pin (addr_lsb_or_mux_select),
    .timing_pin (bus_timing_select),
    .mux_mode (mux_mode),
    .fast_timing (fast_timing)
  );

  strobe_filter #(.CNT_W(2)) u_rd_filter (
    .clock (clock),
    .resetn (resetn),
    .strobe_n (read_strobe_or_data_strobe),
    .select_n (chip_select_n),
    .fast (fast_timing),
    .out (rd_strb)
  );

  // In direction style this filter reports a selected, low direction line.
  strobe_filter #(.CNT_W(2)) u_wr_filter (
    .clock (clock),
    .resetn (resetn),
    .strobe_n (write_strobe_or_direction),
    .select_n (chip_select_n),
    .fast (fast_timing),
    .out (wr_strb)
  );

  // ****************************************************************
  // Access state machine
  // ****************************************************************

  port_s st_reg;
  port_s st_next;
  logic [2:0] cur_addr;
  logic wr_low;

  localparam port_s PORT_RESET = '{
    state: ST_IDLE,
    style: STYLE_SEPARATE,
    addr_latch: `ADDR_RESET,
    access_addr: `ADDR_RESET,
    wdata: `DATA_RESET,
    rdata: `DATA_RESET,
    data_oe_n: 1'b1,
    rd_capture: 1'b0,
    reg_rd: 1'b0,
    reg_wr: 1'b0,
    reg_addr: `ADDR_RESET,
    reg_wdata: `DATA_RESET,
    irq_n: 1'b1,
    dev_reset_n: 1'b0
  };

  // ****************************************************************
  // Cycle decode
  // ****************************************************************

  logic latch_open;
  logic rd_go;
  logic ds_write_go;
  logic sep_write_go;
  logic wr_gone;

  always_comb
  begin
    latch_open = mux_mode && addr_msb_or_latch_strobe;
    cur_addr = mux_mode ? st_reg.addr_latch
      : {addr_msb_or_latch_strobe, addr_middle_bit, addr_lsb_or_mux_select};

    // A low direction line counts only once its filter has qualified it.
    wr_low = wr_strb.active && (write_strobe_or_direction == `DIR_LEVEL_WRITE);
    rd_go = rd_strb.active && !wr_low;
    ds_write_go = rd_strb.active && wr_low;

    // Once direction style is known, a low direction line alone is no write.
    sep_write_go = wr_low && (st_reg.style == STYLE_SEPARATE);

    // The raw pin ends a write at once; the filter only delays its start.
    wr_gone = !wr_low;
  end

  // ****************************************************************
  // Next state
  // ****************************************************************

  always_comb
  begin
    st_next = st_reg;
    st_next.reg_rd = 1'b0;
    st_next.reg_wr = 1'b0;
    st_next.rd_capture = 1'b0;
    st_next.dev_reset_n = 1'b1;
    st_next.irq_n = !irq_pending;

    // The multiplexed address is caught while the latch strobe is high and held after.
    if (latch_open)
    begin
      st_next.addr_latch = data_in[2:0];
    end

    case (st_reg.state)
      ST_IDLE:
      begin
        st_next.data_oe_n = 1'b1;
        if (rd_go)
        begin
          // Read: separate read strobe or data strobe with direction high.
          st_next.state = ST_READ;
          st_next.reg_rd = 1'b1;
          st_next.reg_addr = cur_addr;
          st_next.rd_capture = 1'b1;
        end
        else if (ds_write_go)
        begin
          // Both strobe pins low never happens with separate strobes.
          st_next.style = STYLE_DIRECTION;
          st_next.state = ST_DS_WRITE;
          st_next.access_addr = cur_addr;
          st_next.wdata = data_in;
        end
        else if (sep_write_go)
        begin
          st_next.state = ST_WR_PEND;
          st_next.access_addr = cur_addr;
          st_next.wdata = data_in;
        end
      end
      ST_WR_PEND:
      begin
        if (rd_strb.active)
        begin
          // A data strobe arrived under a low direction line.
          st_next.style = STYLE_DIRECTION;
          st_next.state = ST_DS_WRITE;
          st_next.wdata = data_in;
        end
        else if (wr_gone)
        begin
          // Write strobe ended with the read strobe idle throughout.
          st_next.style = STYLE_SEPARATE;
          st_next.state = ST_IDLE;
          st_next.reg_wr = 1'b1;
          st_next.reg_addr = st_reg.access_addr;
          st_next.reg_wdata = st_reg.wdata;
        end
        else
        begin
          st_next.wdata = data_in;
        end
      end
      ST_DS_WRITE:
      begin
        if (!rd_strb.active)
        begin
          st_next.state = ST_IDLE;
          st_next.reg_wr = 1'b1;
          st_next.reg_addr = st_reg.access_addr;
          st_next.reg_wdata = st_reg.wdata;
        end
        else
        begin
          st_next.wdata = data_in;
        end
      end
      ST_READ:
      begin
        if (st_reg.rd_capture)
        begin
          st_next.rdata = reg_rdata;
          st_next.data_oe_n = 1'b0;
        end
        if (!rd_strb.active)
        begin
          // Strobe or chip select released: let go of the data lines.
          st_next.state = ST_IDLE;
          st_next.data_oe_n = 1'b1;
        end
      end
      default:
      begin
        st_next = PORT_RESET;
      end
    endcase

    if (!hw_reset_n)
    begin
      st_next = PORT_RESET;
    end
  end

  always_ff @(posedge clock or negedge resetn)
  begin
    if (!resetn)
    begin
      st_reg <= PORT_RESET;
    end
    else
    begin
      st_reg <= st_next;
    end
  end

  // ****************************************************************
  // Outputs
  // ****************************************************************

  // Host pins.
  assign data_out = st_reg.rdata;
  assign data_oe_n = st_reg.data_oe_n;
  assign irq_out_n = st_reg.irq_n;

  // Register side.
  assign reg_addr = st_reg.reg_addr;
  assign reg_wdata = st_reg.reg_wdata;
  assign reg_wr = st_reg.reg_wr;
  assign reg_rd = st_reg.reg_rd;

  // Status, each bit taken straight from its flip-flop.
  assign dev_reset_n = st_reg.dev_reset_n;
  assign style_direction = st_reg.style;

endmodule : host_cpu_bus_interface

// file: logic/host_bus_map.svh
// Constants of the parallel host port: strobe sampling counts and pin levels.
// Assumes inclusion by the package and the modules of the host port.
`ifndef HOST_BUS_MAP_SVH
`define HOST_BUS_MAP_SVH

// Samples a strobe must stay low before it counts, per timing mode.
`define STROBE_SAMPLES_FAST 2'h1
`define STROBE_SAMPLES_NORMAL 2'h2

// Pin levels.
`define DIR_LEVEL_WRITE 1'b0
`define MUX_SELECT_LEVEL 1'b0
`define FAST_TIMING_LEVEL 1'b0

// Reset values.
`define ADDR_RESET 3'h0
`define DATA_RESET 8'h00

`endif

// file: logic/host_bus_pkg.sv
// Types of the parallel host port: access states, strobe style and state records.
// Assumes the constants header is on the include path.
`include "host_bus_map.svh"

package host_bus_pkg;

  typedef enum logic [3:0] {
    ST_IDLE = 4'h1,
    ST_WR_PEND = 4'h2,
    ST_READ = 4'h4,
    ST_DS_WRITE = 4'h8
  } access_e;

  typedef enum logic {
    STYLE_SEPARATE = 1'b0,
    STYLE_DIRECTION = 1'b1
  } bus_style_e;

  typedef struct packed {
    logic [1:0] cnt;
    logic active;
    logic start;
    logic done;
  } filter_s;

  typedef struct packed {
    logic armed;
    logic mux_mode;
    logic fast_timing;
  } strap_s;

  typedef struct packed {
    access_e state;
    bus_style_e style;
    logic [2:0] addr_latch;
    logic [2:0] access_addr;
    logic [7:0] wdata;
    logic [7:0] rdata;
    logic data_oe_n;
    logic rd_capture;
    logic reg_rd;
    logic reg_wr;
    logic [2:0] reg_addr;
    logic [7:0] reg_wdata;
    logic irq_n;
    logic dev_reset_n;
  } port_s;

endpackage : host_bus_pkg

// file: logic/strobe_if.sv
// Qualified strobe status passed from a strobe filter to the port logic.
// Assumes one instance per filtered strobe.
`timescale 1ns/1ps

interface strobe_if;
  logic active;
  logic start;
  logic done;

  modport src (output active, output start, output done);
  modport dst (input active, input start, input done);
endinterface : strobe_if

// file: logic/strobe_filter.sv
// Qualifies one active-low strobe with chip select and a minimum low time.
// Assumes inputs synchronous to clock.
`timescale 1ns/1ps

module strobe_filter
  import host_bus_pkg::*;
#(
  parameter int CNT_W = 2
)
(
  // Clock and reset
  input wire logic clock,
  input wire logic resetn,
  // Pins
  input wire logic strobe_n,
  input wire logic select_n,
  input wire logic fast,
  // Result
  strobe_if.src out
);

  filter_s st_reg;
  filter_s st_next;
  logic [CNT_W-1:0] need;

  always_comb
  begin
    need = fast ? CNT_W'(`STROBE_SAMPLES_FAST) : CNT_W'(`STROBE_SAMPLES_NORMAL);
    st_next = st_reg;
    if (!strobe_n && !select_n)
    begin
      if (st_reg.cnt != need)
      begin
        st_next.cnt = st_reg.cnt + 2'h1;
      end
    end
    else
    begin
      st_next.cnt = 2'h0;
    end
    st_next.active = (st_next.cnt == need);
    st_next.start = st_next.active && !st_reg.active;
    st_next.done = !st_next.active && st_reg.active;
  end

  always_ff @(posedge clock or negedge resetn)
  begin
    if (!resetn)
    begin
      st_reg <= '0;
    end
    else
    begin
      st_reg <= st_next;
    end
  end

  assign out.active = st_reg.active;
  assign out.start = st_reg.start;
  assign out.done = st_reg.done;

endmodule : strobe_filter

// file: logic/strap_capture.sv
// Captures the bus mode and timing straps while the hardware reset is low
// and in the first cycle after the internal reset releases.
// Assumes straps are stable around reset.
`timescale 1ns/1ps

module strap_capture
  import host_bus_pkg::*;
(
  // Clock and reset
  input wire logic clock,
  input wire logic resetn,
  // Straps
  input wire logic hw_reset_n,
  input wire logic mux_select_pin,
  input wire logic timing_pin,
  // Captured modes
  output logic mux_mode,
  output logic fast_timing
);

  strap_s st_reg;
  strap_s st_next;

  always_comb
  begin
    st_next = st_reg;
    st_next.armed = 1'b0;
    if (st_reg.armed || !hw_reset_n)
    begin
      st_next.mux_mode = (mux_select_pin == `MUX_SELECT_LEVEL);
      st_next.fast_timing = (timing_pin == `FAST_TIMING_LEVEL)
        && (mux_select_pin != `MUX_SELECT_LEVEL);
    end
  end

  always_ff @(posedge clock or negedge resetn)
  begin
    if (!resetn)
    begin
      st_reg <= '{armed: 1'b1, mux_mode: 1'b0, fast_timing: 1'b0};
    end
    else
    begin
      st_reg <= st_next;
    end
  end

  assign mux_mode = st_reg.mux_mode;
  assign fast_timing = st_reg.fast_timing;

endmodule : strap_capture

// file: test/host_bus_props.sv
// Checker of the parallel host port: request timing, pin drive, reset.
// Assumes binding into the port's top module, one clock domain.
`timescale 1ns/1ps

module host_bus_props
(
  // Clock and reset
  input wire logic clock,
  input wire logic resetn,
  // Host pins
  input wire logic chip_select_n,
  input wire logic write_strobe_or_direction,
  input wire logic read_strobe_or_data_strobe,
  input wire logic hw_reset_n,
  input wire logic data_oe_n,
  input wire logic irq_out_n,
  // Register side and status
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic irq_pending,
  input wire logic dev_reset_n,
  input wire logic style_direction,
  input wire logic mux_mode,
  input wire logic fast_timing
);
  // ****
  // Properties
  // ****
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!resetn);
  sequence s_deselected;
    chip_select_n [*5];
  endsequence
  sequence s_read_seen;
    $past(read_strobe_or_data_strobe, 2) == 1'b0 && $past(chip_select_n, 2) == 1'b0;
  endsequence
  property p_deselect;
    s_deselected |-> !reg_wr && !reg_rd;
  endproperty
  property p_read;
    reg_rd |-> s_read_seen;
  endproperty
  property p_read_normal;
    reg_rd && !fast_timing |-> $past(read_strobe_or_data_strobe, 3) == 1'b0;
  endproperty
  property p_write_sep;
    reg_wr && !style_direction |-> $past(write_strobe_or_direction, 2) == 1'b0
      && $past(write_strobe_or_direction, 1) == 1'b1;
  endproperty
  property p_write_dir;
    reg_wr && style_direction |-> $past(read_strobe_or_data_strobe, 4) == 1'b0
      && $past(write_strobe_or_direction, 4) == 1'b0;
  endproperty
  property p_read_dir;
    reg_rd && style_direction |-> $past(write_strobe_or_direction, 2) == 1'b1;
  endproperty
  property p_pulse;
    reg_wr || reg_rd |=> !reg_wr && !reg_rd;
  endproperty
  property p_drive;
    !data_oe_n |-> $past(chip_select_n, 3) == 1'b0 && $past(read_strobe_or_data_strobe, 3) == 1'b0
      && $past(write_strobe_or_direction, 3) == 1'b1;
  endproperty
  property p_irq;
    $past(hw_reset_n) && $past(resetn) |-> irq_out_n == !$past(irq_pending);
  endproperty
  property p_hw_reset;
    !hw_reset_n |=> !dev_reset_n && irq_out_n && data_oe_n;
  endproperty
  property p_strap;
    mux_mode |-> !fast_timing;
  endproperty
  a_deselect: assert property (p_deselect) else $error("request while deselected");
  a_read: assert property (p_read) else $error("read without strobe");
  a_read_normal: assert property (p_read_normal) else $error("short strobe");
  a_write_sep: assert property (p_write_sep) else $error("write timing");
  a_write_dir: assert property (p_write_dir) else $error("direction write");
  a_read_dir: assert property (p_read_dir) else $error("direction read");
  a_pulse: assert property (p_pulse) else $error("long request pulse");
  a_drive: assert property (p_drive) else $error("drive outside read");
  a_irq: assert property (p_irq) else $error("interrupt pin");
  a_hw_reset: assert property (p_hw_reset) else $error("hardware reset");
  a_strap: assert property (p_strap) else $error("fast with mux");
endmodule : host_bus_props

bind host_cpu_bus_interface host_bus_props u_props (.clock, .resetn, .chip_select_n,
  .write_strobe_or_direction, .read_strobe_or_data_strobe, .hw_reset_n, .data_oe_n,
  .irq_out_n, .reg_wr, .reg_rd, .irq_pending, .dev_reset_n, .style_direction, .mux_mode,
  .fast_timing);

// file: test/host_bus_model.sv
// Host bus master model: one task runs a whole bus cycle.
// Assumes the bench sets mux to match the captured strap.
`timescale 1ns/1ps

module host_bus_model
(
  // Clock
  input wire logic clock,
  // Port drive
  input wire logic [7:0] data_out,
  input wire logic data_oe_n,
  // Host pins
  output logic [2:0] addr,
  output logic cs_n,
  output logic wr_n,
  output logic rd_n,
  output logic [7:0] data_pin
);
  logic drive;
  logic mux;
  logic [7:0] drive_val;
  // Undriven data lines float high through the pull-ups.
  assign data_pin = !data_oe_n ? data_out : drive ? drive_val : 8'hff;
  initial
  begin
    addr = 3'h1;
    cs_n = 1'b1;
    wr_n = 1'b1;
    rd_n = 1'b1;
    drive = 1'b0;
    drive_val = 8'h00;
    mux = 1'b0;
  end
  // ****
  // Bus cycle
  // ****
  task automatic xfer(input logic dirs, input logic wr, input logic sel,
    input logic [2:0] a, input logic [7:0] d, output logic [7:0] q);
    @(negedge clock);
    if (mux)
    begin
      addr[2] = 1'b1;
      drive = 1'b1;
      drive_val = {5'h00, a};
      @(negedge clock);
      addr[2] = 1'b0;
    end
    else
      addr = a;
    drive = wr;
    drive_val = d;
    cs_n = !sel;
    wr_n = !wr;
    rd_n = wr && !dirs;
    repeat (8) @(negedge clock);
    q = data_pin;
    rd_n = 1'b1;
    // Direction stays low past the data strobe so the end is no write strobe.
    if (!dirs)
      wr_n = 1'b1;
    @(negedge clock);
    wr_n = 1'b1;
    cs_n = 1'b1;
    drive = 1'b0;
    repeat (5) @(negedge clock);
  endtask : xfer
endmodule : host_bus_model

// file: test/host_cpu_bus_interface_test.sv
// Bench of the parallel host port: scenario tasks drive a host model and judge results.
// Assumes the host model and the checker are compiled alongside.
`timescale 1ns/1ps

module host_cpu_bus_interface_test;
  logic clock, resetn, hw_reset_n, bus_timing_select, irq_pending;
  logic cs_n, wr_n, rd_n, data_oe_n, irq_out_n, reg_wr, reg_rd;
  logic dev_reset_n, style_direction, mux_mode, fast_timing;
  logic [2:0] addr, reg_addr;
  logic [7:0] data_pin, data_out, reg_wdata, reg_rdata;
  int bad_count, n_compared, wr_seen, rd_seen;
  assign reg_rdata = {5'h1a, reg_addr};
  host_cpu_bus_interface u_dut (.clock, .resetn, .addr_lsb_or_mux_select(addr[0]),
    .addr_middle_bit(addr[1]), .addr_msb_or_latch_strobe(addr[2]), .chip_select_n(cs_n),
    .write_strobe_or_direction(wr_n), .read_strobe_or_data_strobe(rd_n), .hw_reset_n,
    .bus_timing_select, .data_in(data_pin), .data_out, .data_oe_n, .irq_out_n, .reg_addr,
    .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .irq_pending, .dev_reset_n, .style_direction,
    .mux_mode, .fast_timing);
  host_bus_model u_host (.clock, .data_out, .data_oe_n, .addr, .cs_n, .wr_n, .rd_n, .data_pin);
  initial
  begin
    clock = 1'b0;
    forever #20 clock = ~clock;
  end
  always @(posedge clock)
  begin
    wr_seen += (reg_wr === 1'b1);
    rd_seen += (reg_rd === 1'b1);
  end
  // ****
  // Shared tasks
  // ****
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    n_compared++;
    if (seen !== exp)
    begin
      $display("mismatch t=%0t seen=%h exp=%h", $time, seen, exp);
      bad_count++;
    end
  endtask : check
  task automatic conclude;
    $display("compared %0d mismatched %0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : conclude
  task automatic wait_count(input bit rd, input int want);
    for (int i = 0; i < 20 && (rd ? rd_seen : wr_seen) != want; i++)
      @(negedge clock);
    if ((rd ? rd_seen : wr_seen) != want)
    begin
      bad_count++;
      conclude();
    end
  endtask : wait_count
  // ****
  // Scenarios
  // ****
  task automatic t_separate;
    logic [7:0] q;
    for (int i = 0; i < 8; i++)
    begin
      u_host.xfer(1'b0, 1'b1, 1'b1, 3'(i), {~3'(i), 2'h2, 3'(i)}, q);
      wait_count(1'b0, i + 1);
      check({5'h00, reg_addr}, {5'h00, 3'(i)});
      check(reg_wdata, {~3'(i), 2'h2, 3'(i)});
      u_host.xfer(1'b0, 1'b0, 1'b1, 3'(i), 8'h00, q);
      wait_count(1'b1, i + 1);
      check(q, {5'h1a, 3'(i)});
    end
    check({7'h00, style_direction}, 8'h00);
  endtask : t_separate
  task automatic t_deselect;
    logic [7:0] q;
    u_host.xfer(1'b0, 1'b1, 1'b0, 3'h2, 8'h77, q);
    u_host.xfer(1'b0, 1'b0, 1'b0, 3'h2, 8'h00, q);
    check(q, 8'hff);
    check(8'(wr_seen + rd_seen), 8'h10);
  endtask : t_deselect
  task automatic t_irq;
    irq_pending = 1'b1;
    repeat (2) @(negedge clock);
    check({7'h00, irq_out_n}, 8'h00);
    irq_pending = 1'b0;
    repeat (2) @(negedge clock);
    check({7'h00, irq_out_n}, 8'h01);
  endtask : t_irq
  task automatic t_direction;
    logic [7:0] q;
    u_host.xfer(1'b1, 1'b1, 1'b1, 3'h4, 8'hc3, q);
    wait_count(1'b0, 9);
    check(reg_wdata, 8'hc3);
    check({7'h00, style_direction}, 8'h01);
    u_host.xfer(1'b1, 1'b0, 1'b1, 3'h1, 8'h00, q);
    wait_count(1'b1, 9);
    check(q, 8'hd1);
  endtask : t_direction
  task automatic t_mux;
    logic [7:0] q;
    hw_reset_n = 1'b0;
    u_host.addr = 3'h2;
    bus_timing_select = 1'b1;
    u_host.mux = 1'b1;
    repeat (3) @(negedge clock);
    check({7'h00, dev_reset_n}, 8'h00);
    hw_reset_n = 1'b1;
    repeat (3) @(negedge clock);
    check({6'h00, mux_mode, fast_timing}, 8'h02);
    check({7'h00, style_direction}, 8'h00);
    u_host.xfer(1'b0, 1'b1, 1'b1, 3'h3, 8'h5c, q);
    wait_count(1'b0, 10);
    check({reg_wdata[7:3], reg_addr}, 8'h5b);
    u_host.xfer(1'b0, 1'b0, 1'b1, 3'h6, 8'h00, q);
    wait_count(1'b1, 10);
    check(q, 8'hd6);
  endtask : t_mux
  initial
  begin
    bad_count = 0;
    n_compared = 0;
    wr_seen = 0;
    rd_seen = 0;
    resetn = 1'b0;
    hw_reset_n = 1'b1;
    bus_timing_select = 1'b0;
    irq_pending = 1'b0;
    repeat (8) @(negedge clock);
    resetn = 1'b1;
    repeat (3) @(negedge clock);
    check({5'h00, dev_reset_n, mux_mode, fast_timing}, 8'h05);
    t_separate();
    t_deselect();
    t_irq();
    t_direction();
    t_mux();
    conclude();
  end
endmodule : host_cpu_bus_interface_test
